//--- design/global_pin_control.sv
`timescale 1ns/100ps
`default_nettype none

module global_pin_control
    import global_pin_pkg::*;
#(
    parameter int unsigned CHANNELS = NUM_CHANNELS,
    parameter int unsigned BITS     = WORD_BITS
) (
    input  wire logic                mclk,
    input  wire logic                rst,
    input  wire logic                chip_reset_n,
    input  wire logic                tx_driver_tristate,
    input  wire logic                serial_out_edge_select,
    input  wire logic                sclk,
    input  wire logic                host_serial_in,
    input  wire logic [BITS-1:0]     status_word,
    input  wire logic [CHANNELS-1:0] line_drive_req,
    output logic      [CHANNELS-1:0] line_drive_oe,
    output logic                     host_serial_out,
    output logic      [BITS-1:0]     config_word,
    output logic                     chip_in_reset
);

    ////////////////////////////////////////////////////////////////////////
    // Pin synchronisation

    pin_sample_t pins_raw;
    pin_sample_t pins;

    assign pins_raw = '{sclk: sclk, host_serial_in: host_serial_in,
                        tx_driver_tristate: tx_driver_tristate,
                        serial_out_edge_select: serial_out_edge_select,
                        chip_reset_n: chip_reset_n};

    pin_sync #(
        .WIDTH ($bits(pin_sample_t))
    ) u_sync (
        .mclk     (mclk),
        .rst      (rst),
        .async_in (pins_raw),
        .sync_out (pins)
    );

    ////////////////////////////////////////////////////////////////////////
    // Reset pin filter: low for RESET_MIN_CYCLES samples resets the chip

    logic [3:0] low_count;
    logic       hw_reset;

    always_ff @(posedge mclk) begin
        if (rst) begin
            low_count <= 4'h0;
            hw_reset  <= 1'b0;
        end else if (pins.chip_reset_n) begin
            low_count <= 4'h0;
            hw_reset  <= 1'b0;
        end else if (low_count >= 4'(RESET_MIN_CYCLES - 1)) begin
            hw_reset  <= 1'b1;
        end else begin
            low_count <= low_count + 4'h1;
        end
    end

    // Reset status output
    always_ff @(posedge mclk) begin
        if (rst) begin
            chip_in_reset <= 1'b1;
        end else begin
            chip_in_reset <= hw_reset;
        end
    end

    logic core_rst;
    assign core_rst = rst | hw_reset;

    ////////////////////////////////////////////////////////////////////////
    // Line driver enables

    always_ff @(posedge mclk) begin
        if (core_rst) begin
            line_drive_oe <= '0;
        end else if (pins.tx_driver_tristate) begin
            line_drive_oe <= '0;
        end else begin
            line_drive_oe <= line_drive_req;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Serial clock edge detection

    logic sclk_prev;
    logic sclk_rise;
    logic sclk_fall;
    logic out_edge;

    always_ff @(posedge mclk) begin
        if (core_rst) begin
            sclk_prev <= 1'b0;
        end else begin
            sclk_prev <= pins.sclk;
        end
    end

    assign sclk_rise = pins.sclk & ~sclk_prev;
    assign sclk_fall = ~pins.sclk & sclk_prev;
    // Selected launch edge
    assign out_edge  = (edge_sel_t'(pins.serial_out_edge_select) == EDGE_FALLING) ? sclk_fall : sclk_rise;

    ////////////////////////////////////////////////////////////////////////
    // Serial input shifter: words land in config_word
    // Runs regardless of the tristate pin

    logic [BITS-1:0] in_shift;
    logic [3:0]      in_count;

    always_ff @(posedge mclk) begin
        if (core_rst) begin
            in_shift    <= BITS'(SHIFT_RESET);
            in_count    <= 4'h0;
            config_word <= BITS'(CFG_RESET);
        end else if (sclk_rise) begin
            in_shift <= {in_shift[BITS-2:0], pins.host_serial_in};
            if (in_count == 4'(BITS - 1)) begin
                in_count    <= 4'h0;
                config_word <= {in_shift[BITS-2:0], pins.host_serial_in};
            end else begin
                in_count <= in_count + 4'h1;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Serial output shifter: status read data, MSB first

    logic [BITS-1:0] out_shift;
    logic [3:0]      out_count;

    always_ff @(posedge mclk) begin
        if (core_rst) begin
            out_shift       <= BITS'(SHIFT_RESET);
            out_count       <= 4'h0;
            host_serial_out <= 1'b0;
        end else if (out_edge) begin
            if (out_count == 4'h0) begin
                host_serial_out <= status_word[BITS-1];
                out_shift       <= {status_word[BITS-2:0], 1'b0};
            end else begin
                host_serial_out <= out_shift[BITS-1];
                out_shift       <= {out_shift[BITS-2:0], 1'b0};
            end
            out_count <= (out_count == 4'(BITS - 1)) ? 4'h0 : out_count + 4'h1;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Checks

    sequence s_reset_low_long;
        !pins.chip_reset_n [*3];
    endsequence

    AST_RESET_TAKES: assert property (@(posedge mclk) disable iff (rst)
        s_reset_low_long |-> ##[0:2] hw_reset)
        else $error("Long reset pulse did not reset chip");

    AST_RESET_DRIVERS_OFF: assert property (@(posedge mclk) disable iff (rst)
        hw_reset |=> line_drive_oe == '0)
        else $error("Drivers enabled during reset");

    AST_RESET_CONFIG: assert property (@(posedge mclk) disable iff (rst)
        hw_reset |=> config_word == BITS'(CFG_RESET))
        else $error("Config not at default after reset");

    AST_TRISTATE_HIGH: assert property (@(posedge mclk) disable iff (rst)
        pins.tx_driver_tristate |=> line_drive_oe == '0)
        else $error("Drivers not tristated");

    AST_TRISTATE_LOW: assert property (@(posedge mclk) disable iff (rst)
        (!pins.tx_driver_tristate && !core_rst) |=> line_drive_oe == $past(line_drive_req))
        else $error("Drivers not enabled");

    AST_INTERNAL_RUNS: assert property (@(posedge mclk) disable iff (core_rst)
        (sclk_rise && pins.tx_driver_tristate) |=> in_shift[0] == $past(pins.host_serial_in))
        else $error("Shifter stalled by tristate pin");

    AST_OUT_EDGE: assert property (@(posedge mclk) disable iff (core_rst)
        (!out_edge) |=> $stable(host_serial_out))
        else $error("Serial output moved off the active edge");

    AST_SAMPLE_RISE: assert property (@(posedge mclk) disable iff (core_rst)
        !sclk_rise |=> $stable(in_shift))
        else $error("Input sampled off rising edge");

    AST_SHIFT_OUT: assert property (@(posedge mclk) disable iff (core_rst)
        (out_edge && out_count != 4'h0) |=> host_serial_out == $past(out_shift[BITS-1]))
        else $error("Wrong serial output bit");

    AST_STATUS_FOLLOWS: assert property (@(posedge mclk) disable iff (rst)
        hw_reset |=> chip_in_reset)
        else $error("Reset status not raised");

    AST_RESET_RELEASE: assert property (@(posedge mclk) disable iff (rst)
        pins.chip_reset_n |=> !hw_reset)
        else $error("Chip reset held with pin high");

    AST_RESET_COUNTS: assert property (@(posedge mclk) disable iff (rst)
        hw_reset |=> (in_count == 4'h0 && out_count == 4'h0))
        else $error("Bit counters not cleared by reset");

    AST_RESET_SERIAL_OUT: assert property (@(posedge mclk) disable iff (rst)
        hw_reset |=> host_serial_out == 1'b0)
        else $error("Serial output not cleared by reset");

endmodule : global_pin_control

`default_nettype wire

//--- design/global_pin_pkg.sv
package global_pin_pkg;

    // Clock rate and timing
    localparam int unsigned MCLK_PERIOD_NS   = 50;
    localparam int unsigned RESET_MIN_NS     = 100;
    // More than the least time: round up, then one more cycle
    localparam int unsigned RESET_MIN_CYCLES = (RESET_MIN_NS + MCLK_PERIOD_NS - 1) / MCLK_PERIOD_NS + 1;

    // Channel count and serial word length
    localparam int unsigned NUM_CHANNELS = 4;
    localparam int unsigned WORD_BITS    = 8;

    // Reset values
    localparam logic [7:0] SHIFT_RESET = 8'h00;
    localparam logic [7:0] CFG_RESET   = 8'h00;

    // Serial clock edge selection
    typedef enum logic [0:0] {
        EDGE_RISING  = 1'b0,
        EDGE_FALLING = 1'b1
    } edge_sel_t;

    // Synchronised pins travelling together
    typedef struct packed {
        logic sclk;
        logic host_serial_in;
        logic tx_driver_tristate;
        logic serial_out_edge_select;
        logic chip_reset_n;
    } pin_sample_t;

endpackage : global_pin_pkg

//--- design/pin_sync.sv
`timescale 1ns/100ps
`default_nettype none

module pin_sync
    import global_pin_pkg::*;
#(
    parameter int unsigned WIDTH = 5
) (
    input  wire logic             mclk,
    input  wire logic             rst,
    input  wire logic [WIDTH-1:0] async_in,
    output logic      [WIDTH-1:0] sync_out
);

    logic [WIDTH-1:0] stage1;

    // Two flip-flops per bit; stage1 is read only by sync_out
    genvar i;
    generate
        for (i = 0; i < WIDTH; i++) begin : g_bit
            always_ff @(posedge mclk) begin
                if (rst) begin
                    stage1[i]   <= 1'b0;
                    sync_out[i] <= 1'b0;
                end else begin
                    stage1[i]   <= async_in[i];
                    sync_out[i] <= stage1[i];
                end
            end
        end
    endgenerate

endmodule : pin_sync

`default_nettype wire

//--- tb/global_pin_control_tb.sv
`timescale 1ns/100ps
`default_nettype none

module global_pin_control_tb;
    import global_pin_pkg::*;

    logic       mclk                   = 1'b0;
    logic       rst                    = 1'b1;
    logic       chip_reset_n           = 1'b1;
    logic       tx_driver_tristate     = 1'b0;
    logic       serial_out_edge_select = 1'b0;
    logic [7:0] status_word            = 8'h00;
    logic [3:0] line_drive_req         = 4'h0;
    logic       sclk;
    logic       host_serial_in;
    logic [3:0] line_drive_oe;
    logic       host_serial_out;
    logic [7:0] config_word;
    logic       chip_in_reset;
    logic [7:0] rx;
    int         n_errors               = 0;
    int         comparisons            = 0;

    always #25 mclk = ~mclk;

    global_pin_control global_pin_control_i (
        .mclk(mclk), .rst(rst), .chip_reset_n(chip_reset_n),
        .tx_driver_tristate(tx_driver_tristate), .serial_out_edge_select(serial_out_edge_select),
        .sclk(sclk), .host_serial_in(host_serial_in), .status_word(status_word),
        .line_drive_req(line_drive_req), .line_drive_oe(line_drive_oe),
        .host_serial_out(host_serial_out), .config_word(config_word), .chip_in_reset(chip_in_reset)
    );

    host_model host_model_i (
        .sclk(sclk), .host_serial_in(host_serial_in),
        .host_serial_out(host_serial_out), .serial_out_edge_select(serial_out_edge_select)
    );

    ////////////////////////////////////////////////////////////////////////////////
    // Helpers
    task automatic tick(input int n);
        repeat (n) @(posedge mclk);
        #1;
    endtask : tick

    task automatic check(input logic [7:0] got, input logic [7:0] exp, input string msg);
        comparisons++;
        if (got !== exp) begin
            n_errors++;
            $display("CHECK FAILED %0t %s", $time, msg);
        end
    endtask : check

    task automatic conclude();
        $display("errors %0d comparisons %0d", n_errors, comparisons);
        if (n_errors == 0 && comparisons > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask : conclude

    ////////////////////////////////////////////////////////////////////////////////
    // Scenarios
    task automatic test_drivers();
        line_drive_req = 4'ha;
        tick(5);
        check({4'h0, line_drive_oe}, 8'h0a, "drivers not enabled");
        line_drive_req     = 4'hf;
        tx_driver_tristate = 1'b1;
        tick(5);
        check({4'h0, line_drive_oe}, 8'h00, "drivers not tristated");
    endtask : test_drivers

    task automatic test_serial_in();
        host_model_i.frame(8'hc5, rx);
        tick(2);
        check(config_word, 8'hc5, "word lost while tristated");
        tx_driver_tristate = 1'b0;
    endtask : test_serial_in

    task automatic test_serial_out(input logic sel, input logic [7:0] word);
        serial_out_edge_select = sel;
        status_word            = word;
        tick(5);
        host_model_i.frame(8'h3a, rx);
        check(rx, word, "serial out word");
    endtask : test_serial_out

    task automatic test_hw_reset();
        host_model_i.partial(3); // Leave both bit counters mid-word
        tick(1);
        chip_reset_n = 1'b0;
        tick(1);
        chip_reset_n = 1'b1;
        tick(8);
        check({7'h00, chip_in_reset}, 8'h00, "short pulse reset chip");
        chip_reset_n = 1'b0;
        tick(9);
        check({7'h00, chip_in_reset}, 8'h01, "no reset after long pulse");
        check({4'h0, line_drive_oe}, 8'h00, "drivers on during reset");
        check(config_word, CFG_RESET, "config not cleared");
        chip_reset_n = 1'b1;
        tick(6);
        check({4'h0, line_drive_oe}, 8'h0f, "drivers off after reset");
        host_model_i.frame(8'h81, rx);
        tick(2);
        check(config_word, 8'h81, "bit count not cleared");
        check(rx, 8'h4b, "output bit count not cleared");
    endtask : test_hw_reset

    ////////////////////////////////////////////////////////////////////////////////
    // Main sequence and watchdog
    initial begin
        tick(12);
        rst = 1'b0;
        tick(3);
        test_drivers();
        test_serial_in();
        test_serial_out(EDGE_RISING, 8'h96);
        test_serial_out(EDGE_FALLING, 8'h4b);
        test_hw_reset();
        conclude();
    end

    initial begin
        #100000;
        n_errors++;
        conclude();
    end
endmodule : global_pin_control_tb

`default_nettype wire

//--- tb/host_model.sv
`timescale 1ns/100ps
`default_nettype none

// Host side of the serial port: makes the serial clock only within frames
module host_model (
    output logic      sclk,
    output logic      host_serial_in,
    input  wire logic host_serial_out,
    input  wire logic serial_out_edge_select
);
    logic [7:0] captured;

    initial begin
        sclk           = 1'b0;
        host_serial_in = 1'b0;
        captured       = 8'h00;
    end

    // Capture each bit 300 ns after its selected edge, once it has settled
    always @(sclk) begin
        if (sclk ^ serial_out_edge_select) begin
            #300;
            captured = {captured[6:0], host_serial_out};
        end
    end

    // One 8-bit frame, MSB first, 400 ns clock period
    task automatic frame(input logic [7:0] tx, output logic [7:0] rx);
        #13;
        for (int i = 7; i >= 0; i--) begin
            host_serial_in = tx[i];
            #200 sclk = 1'b1;
            #200 sclk = 1'b0;
        end
        host_serial_in = ~tx[0]; // Released line shows no stale value
        #400 rx = captured;      // Well after the last capture, even on a falling edge
    endtask : frame

    // A cut frame: a few clock periods, then the clock stops
    task automatic partial(input int unsigned n);
        #13;
        repeat (n) begin
            #200 sclk = 1'b1;
            #200 sclk = 1'b0;
        end
        #300;
    endtask : partial
endmodule : host_model

`default_nettype wire
